// >>> rtl/mic_regs.svh
// register offsets, field positions and reset values of the microphone interface
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH
`define MIC_OFS_CTRL 8'h00
`define MIC_OFS_CLKDIV 8'h04
`define MIC_OFS_DECIM 8'h08
`define MIC_OFS_WMARK 8'h0C
`define MIC_OFS_RANGE 8'h10
`define MIC_OFS_IRQ_STAT 8'h14
`define MIC_OFS_IRQ_CLR 8'h18
`define MIC_OFS_IRQ_EN 8'h1C
`define MIC_OFS_ERR_STAT 8'h20
`define MIC_OFS_VAD_THR 8'h24
`define MIC_OFS_LEVEL0 8'h28
`define MIC_OFS_LEVEL1 8'h2C
`define MIC_OFS_RESULT0 8'h40
`define MIC_OFS_RESULT7 8'h5C
`define MIC_IRQ_WMARK 0
`define MIC_IRQ_ERR 1
`define MIC_IRQ_VAD 2
`define MIC_CHANNELS 8
`define MIC_LANES 4
`define MIC_FIFO_DEPTH 32
`define MIC_PCM_W 24
`define MIC_CLKDIV_RST 8'h04
`define MIC_DECIM_RST 8'h20
`define MIC_WMARK_RST 5'h08
`define MIC_VAD_THR_RST 8'h08
`define MIC_VAD_WIN 7'h40
`define MIC_VAD_MID 7'h20
`define MIC_ZCD_WINS 4'hF
`define MIC_DC_SHIFT 8
`define MIC_RESP_OKAY 2'h0
`define MIC_RESP_SLVERR 2'h2
`endif

// >>> rtl/mic_pkg.sv
// types shared by the microphone interface
package mic_pkg;
   typedef struct packed {
      logic zcd_en;
      logic vad_en;
      logic out_dc_en;
      logic dc_en;
      logic dma_sel;
      logic [7:0] ch_en;
   } ctrl_type;

   typedef struct packed {
      logic vad;
      logic err;
      logic wmark;
   } irq_type;
endpackage

// >>> rtl/microphone_interface.sv
// pulse-density microphone interface with decimation, fifos and voice detect
//
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "mic_regs.svh"
module microphone_interface (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // microphones
   output logic mic_clk,
   input wire logic [3:0] mic_lane_input,
   // requests
   output logic irq,
   output logic dma_req
);
   mic_pkg::ctrl_type ctrl_r;
   mic_pkg::irq_type stat_r;
   mic_pkg::irq_type irq_en_r;
   logic [7:0] clkdiv_r;
   logic [7:0] decim_r;
   logic [4:0] wmark_r;
   logic [3:0] range_r;
   logic [7:0] vad_thr_r;
   logic [7:0] ovf_r;
   logic [7:0] udf_r;
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic irq_r, dma_req_r;
   logic mic_clk_r;
   logic [7:0] div_cnt_r;
   logic rise_ev, fall_ev, div_wrap;
   logic wr_hs, rd_hs, clr_wr;
   logic [7:0] pop, ovf_ev, udf_ev, above_wm;
   logic [23:0] head [8];
   logic [5:0] level [8];
   logic [2:0] rd_ch;
   logic rd_is_result;
   logic wm_hit;
   logic vad_ev;

   // bus handshakes; address and data are taken together on one edge
   assign wr_hs = awvalid & wvalid & awready_r & wready_r;
   assign rd_hs = arvalid & arready_r;
   assign rd_ch = araddr[4:2];
   assign rd_is_result = (araddr >= `MIC_OFS_RESULT0) &&
                         (araddr <= `MIC_OFS_RESULT7) && (araddr[1:0] == 2'h0);
   assign clr_wr = wr_hs && (awaddr == `MIC_OFS_IRQ_CLR) && wstrb[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `MIC_RESP_OKAY;
      end else begin
         awready_r <= awvalid & wvalid & ~awready_r & ~bvalid_r;
         wready_r <= awvalid & wvalid & ~awready_r & ~bvalid_r;
         if (wr_hs) begin
            bvalid_r <= 1'b1;
            case (awaddr)
               `MIC_OFS_CTRL, `MIC_OFS_CLKDIV, `MIC_OFS_DECIM,
               `MIC_OFS_WMARK, `MIC_OFS_RANGE, `MIC_OFS_IRQ_CLR,
               `MIC_OFS_IRQ_EN, `MIC_OFS_VAD_THR:
                  bresp_r <= `MIC_RESP_OKAY;
               default:
                  bresp_r <= `MIC_RESP_SLVERR;
            endcase
         end else if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // control registers, byte lanes honoured
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= '0;
         clkdiv_r <= `MIC_CLKDIV_RST;
         decim_r <= `MIC_DECIM_RST;
         wmark_r <= `MIC_WMARK_RST;
         range_r <= 4'h0;
         irq_en_r <= '0;
         vad_thr_r <= `MIC_VAD_THR_RST;
      end else if (wr_hs) begin
         case (awaddr)
            `MIC_OFS_CTRL: begin
               if (wstrb[0]) ctrl_r.ch_en <= wdata[7:0];
               if (wstrb[1]) ctrl_r[12:8] <= wdata[12:8];
            end
            `MIC_OFS_CLKDIV: if (wstrb[0]) clkdiv_r <= wdata[7:0];
            `MIC_OFS_DECIM: if (wstrb[0]) decim_r <= wdata[7:0];
            `MIC_OFS_WMARK: if (wstrb[0]) wmark_r <= wdata[4:0];
            `MIC_OFS_RANGE: if (wstrb[0]) range_r <= wdata[3:0];
            `MIC_OFS_IRQ_EN: if (wstrb[0]) irq_en_r <= wdata[2:0];
            `MIC_OFS_VAD_THR: if (wstrb[0]) vad_thr_r <= wdata[7:0];
            default: ;
         endcase
      end
   end

   // read channel; a read of a result word pops that channel's fifo
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `MIC_RESP_OKAY;
      end else begin
         arready_r <= arvalid & ~arready_r & ~rvalid_r;
         if (rd_hs) begin
            rvalid_r <= 1'b1;
            rresp_r <= `MIC_RESP_OKAY;
            rdata_r <= 32'h0000_0000;
            if (rd_is_result) begin
               rdata_r <= {{8{head[rd_ch][23]}}, head[rd_ch]};
            end else begin
               case (araddr)
                  `MIC_OFS_CTRL: rdata_r[12:0] <= ctrl_r;
                  `MIC_OFS_CLKDIV: rdata_r[7:0] <= clkdiv_r;
                  `MIC_OFS_DECIM: rdata_r[7:0] <= decim_r;
                  `MIC_OFS_WMARK: rdata_r[4:0] <= wmark_r;
                  `MIC_OFS_RANGE: rdata_r[3:0] <= range_r;
                  `MIC_OFS_IRQ_STAT: rdata_r[2:0] <= stat_r;
                  `MIC_OFS_IRQ_CLR: ;
                  `MIC_OFS_IRQ_EN: rdata_r[2:0] <= irq_en_r;
                  `MIC_OFS_ERR_STAT: rdata_r[15:0] <= {udf_r, ovf_r};
                  `MIC_OFS_VAD_THR: rdata_r[7:0] <= vad_thr_r;
                  `MIC_OFS_LEVEL0:
                     rdata_r <= {2'h0, level[3], 2'h0, level[2],
                                 2'h0, level[1], 2'h0, level[0]};
                  `MIC_OFS_LEVEL1:
                     rdata_r <= {2'h0, level[7], 2'h0, level[6],
                                 2'h0, level[5], 2'h0, level[4]};
                  default: rresp_r <= `MIC_RESP_SLVERR;
               endcase
            end
         end else if (rvalid_r && rready) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // one divider and one clock for every microphone; no per-mic gating
   assign div_wrap = (div_cnt_r >= clkdiv_r);
   assign rise_ev = div_wrap & ~mic_clk_r;
   assign fall_ev = div_wrap & mic_clk_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt_r <= 8'h00;
         mic_clk_r <= 1'b0;
      end else if (ctrl_r.ch_en == 8'h00 && !ctrl_r.vad_en) begin
         div_cnt_r <= 8'h00;
         mic_clk_r <= 1'b0;
      end else if (div_wrap) begin
         div_cnt_r <= 8'h00;
         mic_clk_r <= ~mic_clk_r;
      end else begin
         div_cnt_r <= div_cnt_r + 8'h01;
      end
   end

   // each channel: cic, half-band, dc removal, range, fifo
   for (genvar c = 0; c < `MIC_CHANNELS; c++) begin : g_ch
      // left (0) takes data before the rising edge, right (1) before falling
      wire st = ((c % 2) == 0) ? rise_ev : fall_ev;
      wire pdm_bit = mic_lane_input[c / 2];
      wire run = st & ctrl_r.ch_en[c];
      logic signed [31:0] int1_r, int2_r, comb1_r, comb2_r, hb_r;
      logic signed [31:0] dc1_r, dc2_r;
      logic [7:0] dcnt_r;
      logic hb_ph_r;
      logic signed [31:0] x, int1_nxt, int2_nxt, c1, c2, hb, y1, y2, yr;
      logic dec_tick, push;
      logic [23:0] mem [`MIC_FIFO_DEPTH];
      logic [5:0] wp_r, rp_r;
      wire [5:0] cnt = wp_r - rp_r;

      assign x = pdm_bit ? 32'sd1 : -32'sd1;
      assign int1_nxt = int1_r + x;
      assign int2_nxt = int2_r + int1_nxt;
      assign c1 = int2_nxt - comb1_r;
      assign c2 = c1 - comb2_r;
      assign hb = (hb_r + c2) >>> 1;
      assign y1 = ctrl_r.dc_en ? hb - dc1_r : hb;
      assign y2 = ctrl_r.out_dc_en ? y1 - dc2_r : y1;
      assign yr = y2 <<< range_r;
      assign dec_tick = run && (32'(dcnt_r) + 1 >= 32'(decim_r));
      assign push = dec_tick & hb_ph_r;

      always_ff @(posedge aclk) begin
         if (!aresetn || !ctrl_r.ch_en[c]) begin
            int1_r <= '0;
            int2_r <= '0;
            comb1_r <= '0;
            comb2_r <= '0;
            hb_r <= '0;
            dcnt_r <= 8'h00;
            hb_ph_r <= 1'b0;
         end else if (run) begin
            int1_r <= int1_nxt;
            int2_r <= int2_nxt;
            dcnt_r <= dec_tick ? 8'h00 : dcnt_r + 8'h01;
            if (dec_tick) begin
               comb1_r <= int2_nxt;
               comb2_r <= c1;
               hb_ph_r <= ~hb_ph_r;
               if (!hb_ph_r) hb_r <= c2;
            end
         end
      end

      // leaky averages track the offset; kept across disable on purpose
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            dc1_r <= '0;
            dc2_r <= '0;
         end else if (push) begin
            dc1_r <= dc1_r + ((hb - dc1_r) >>> `MIC_DC_SHIFT);
            dc2_r <= dc2_r + ((y1 - dc2_r) >>> `MIC_DC_SHIFT);
         end
      end

      // a full fifo drops the new sample and flags overflow
      assign pop[c] = rd_hs & rd_is_result & (rd_ch == 3'(c));
      assign ovf_ev[c] = push && (cnt == 6'(`MIC_FIFO_DEPTH));
      assign udf_ev[c] = pop[c] && (cnt == 6'h00);
      assign head[c] = (cnt == 6'h00) ? 24'h00_0000 : mem[rp_r[4:0]];
      assign level[c] = cnt;
      assign above_wm[c] = ~ctrl_r.ch_en[c] | (cnt > {1'b0, wmark_r});

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            wp_r <= 6'h00;
            rp_r <= 6'h00;
         end else begin
            if (push && !ovf_ev[c]) begin
               mem[wp_r[4:0]] <= yr[23:0];
               wp_r <= wp_r + 6'h01;
            end
            if (pop[c] && !udf_ev[c]) rp_r <= rp_r + 6'h01;
         end
      end
   end

   // watermark needs every enabled channel above the level
   assign wm_hit = (ctrl_r.ch_en != 8'h00) && (&above_wm);

   // voice detector on lane 0 left, raw bitstream, separate from filters
   logic [6:0] vad_bits_r, vad_ones_r;
   logic [3:0] vad_wins_r, vad_zc_r;
   logic vad_sign_r;
   wire vad_last = (vad_bits_r == `MIC_VAD_WIN - 7'h01);
   wire [6:0] ones_now = vad_ones_r + {6'h00, mic_lane_input[0]};
   wire vad_pos = (ones_now >= `MIC_VAD_MID);
   wire [6:0] vad_dev = vad_pos ? ones_now - `MIC_VAD_MID :
                                  `MIC_VAD_MID - ones_now;
   wire vad_run = ctrl_r.vad_en & rise_ev;
   wire [3:0] zc_now = vad_zc_r + {3'h0, vad_pos ^ vad_sign_r};
   always_ff @(posedge aclk) begin
      if (!aresetn || !ctrl_r.vad_en) begin
         vad_bits_r <= 7'h00;
         vad_ones_r <= 7'h00;
         vad_wins_r <= 4'h0;
         vad_zc_r <= 4'h0;
         vad_sign_r <= 1'b0;
         vad_ev <= 1'b0;
      end else begin
         vad_ev <= 1'b0;
         if (vad_run) begin
            vad_bits_r <= vad_last ? 7'h00 : vad_bits_r + 7'h01;
            vad_ones_r <= vad_last ? 7'h00 : ones_now;
            if (vad_last) begin
               vad_sign_r <= vad_pos;
               if (!ctrl_r.zcd_en) begin
                  vad_ev <= ({1'b0, vad_dev} > vad_thr_r);
               end else if (vad_wins_r == `MIC_ZCD_WINS) begin
                  vad_wins_r <= 4'h0;
                  vad_zc_r <= 4'h0;
                  vad_ev <= ({4'h0, zc_now} > vad_thr_r);
               end else begin
                  vad_wins_r <= vad_wins_r + 4'h1;
                  vad_zc_r <= zc_now;
               end
            end
         end
      end
   end

   // sticky status: a new event wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stat_r <= '0;
         ovf_r <= 8'h00;
         udf_r <= 8'h00;
      end else begin
         if (clr_wr && wdata[`MIC_IRQ_WMARK]) stat_r.wmark <= 1'b0;
         if (clr_wr && wdata[`MIC_IRQ_ERR]) begin
            stat_r.err <= 1'b0;
            ovf_r <= ovf_ev;
            udf_r <= udf_ev;
         end else begin
            ovf_r <= ovf_r | ovf_ev;
            udf_r <= udf_r | udf_ev;
         end
         if (clr_wr && wdata[`MIC_IRQ_VAD]) stat_r.vad <= 1'b0;
         if (wm_hit && !ctrl_r.dma_sel) stat_r.wmark <= 1'b1;
         if (ovf_ev != 8'h00 || udf_ev != 8'h00) stat_r.err <= 1'b1;
         if (vad_ev) stat_r.vad <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
         dma_req_r <= 1'b0;
      end else begin
         irq_r <= |(stat_r & irq_en_r);
         dma_req_r <= wm_hit & ctrl_r.dma_sel;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign mic_clk = mic_clk_r;
   assign irq = irq_r;
   assign dma_req = dma_req_r;
endmodule

// >>> test/mic_properties.sv
// bus handshake and output checks for the microphone interface
`timescale 1ns/1ps
`include "mic_regs.svh"
module mic_properties (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write channels
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   // read channels
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   input wire logic rready,
   // microphone side and requests
   input wire logic mic_clk,
   input wire logic irq,
   input wire logic dma_req
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_write_ready_pair: assert property (awready == wready)
      else $error("write readies split");
   a_write_take: assert property (
      awvalid && wvalid && !bvalid && !awready |=> awready)
      else $error("write not taken");
   a_write_answer: assert property (awvalid && awready |=> bvalid)
      else $error("write response late");
   a_bresp_hold: assert property (
      bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_read_take: assert property (
      arvalid && !arready && !rvalid |=> arready)
      else $error("read not taken");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_rdata_hold: assert property (
      rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read data dropped");
   a_refused_zero: assert property (
      rvalid && rresp == `MIC_RESP_SLVERR |-> rdata == 32'h0)
      else $error("refused read carries data");
   a_reset_quiet: assert property (disable iff (1'b0)
      !aresetn |=> !mic_clk && !irq && !dma_req && !bvalid && !rvalid)
      else $error("outputs active in reset");
endmodule

bind microphone_interface mic_properties chk_u (
   .aclk(aclk), .aresetn(aresetn),
   .awvalid(awvalid), .awready(awready),
   .wvalid(wvalid), .wready(wready),
   .bresp(bresp), .bvalid(bvalid), .bready(bready),
   .arvalid(arvalid), .arready(arready), .rdata(rdata),
   .rresp(rresp), .rvalid(rvalid), .rready(rready),
   .mic_clk(mic_clk), .irq(irq), .dma_req(dma_req)
);

// >>> test/mic_source.sv
// four pairs of pulse-density microphones on the shared clock
`timescale 1ns/1ps
module mic_source (
   // clocks
   input wire logic aclk,
   input wire logic mic_clk,
   // pattern: 0 left ones and right zeros, 1 random
   input wire logic mode,
   // lanes
   output logic [3:0] lane
);
   logic [3:0] rnd_r;
   logic last_r;
   logic [7:0] idle_r;
   always @(posedge aclk) begin
      rnd_r <= 4'($urandom);
      last_r <= mic_clk;
      if (mic_clk != last_r)
         idle_r <= 8'h00;
      else if (idle_r != 8'hFF)
         idle_r <= idle_r + 8'h01;
   end
   // stopped clock: microphones release the lanes, so show noise
   // left mics drive while the clock is low, right ones while high
   assign lane = (idle_r == 8'hFF || mode) ? rnd_r : {4{~mic_clk}};
endmodule

// >>> test/pdm_mic_decimation_interface_tb.sv
// self-checking bench for the microphone interface
`timescale 1ns/1ps
`include "mic_regs.svh"
module pdm_mic_decimation_interface_tb;
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0] r;
   } note_type;
   localparam logic [1:0] OK = `MIC_RESP_OKAY;
   localparam logic [1:0] SLV = `MIC_RESP_SLVERR;
   localparam logic [31:0] SGN = 32'hFF800000;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic mode = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, mic_clk, irq, dma_req;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [3:0] lane;
   logic [7:0] ofs [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C, 8'h24};
   logic [31:0] rst [7] = '{0, 4, 32'h20, 8, 0, 0, 8};
   logic [31:0] msk [7] = '{32'h1FFF, 32'hFF, 32'hFF, 32'h1F, 32'hF, 7, 32'hFF};
   note_type rq[$];
   logic [1:0] bq[$];
   int miscompares = 0;
   int checks_done = 0;
   always #50 aclk = ~aclk;

   microphone_interface dut_u (.aclk(aclk), .aresetn(aresetn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .mic_clk(mic_clk), .mic_lane_input(lane), .irq(irq),
      .dma_req(dma_req));
   mic_source mics_u (.aclk(aclk), .mic_clk(mic_clk), .mode(mode),
      .lane(lane));

   task automatic complete_run();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk_v(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask
   // answers are compared where they appear, against the oldest note
   always @(posedge aclk) begin
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
         chk_v(rdata & rq[0].m, rq[0].d & rq[0].m);
         chk_v(32'(rresp), 32'(rq[0].r));
         void'(rq.pop_front());
      end
      if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
         chk_v(32'(bresp), 32'(bq.pop_front()));
   end
   function automatic logic pick(input int s);
      case (s)
         0: return irq;
         1: return dma_req;
         2: return arready;
         3: return rvalid;
         4: return bvalid;
         default: return awready | wready;
      endcase
   endfunction
   task automatic await(input int s);
      int n;
      for (n = 0; n < 6000; n++) begin
         @(posedge aclk);
         if (pick(s) === 1'b1) break;
      end
      if (n == 6000) begin
         miscompares++;
         $display("ERROR %0t wait ran out", $time);
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] r);
      bq.push_back(r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      await(5);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      if ((awready & wready) !== 1'b1) begin
         await(5);
         awvalid <= 1'b0;
         wvalid <= 1'b0;
      end
      await(4);
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m, input logic [1:0] r);
      rq.push_back('{d, m, r});
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      await(2);
      arvalid <= 1'b0;
      await(3);
      rready <= 1'b0;
   endtask
   task automatic do_reset();
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   initial begin
      logic [31:0] v;
      int i;
      void'($urandom(32'hF828));
      do_reset();
      for (i = 0; i < 7; i++) rd(ofs[i], rst[i], '1, OK);
      for (i = 0; i < 7; i++) begin
         v = $urandom;
         wr(ofs[i], v, OK);
         rd(ofs[i], v & msk[i], msk[i], OK);
      end
      $display("registers done");
      do_reset();
      wr(8'h30, 32'h1, SLV);
      wr(`MIC_OFS_RESULT7, 32'h1, SLV);
      rd(8'h60, 32'h0, '1, SLV);
      rd(`MIC_OFS_IRQ_CLR, 32'h0, '1, OK);
      rd(`MIC_OFS_RESULT0 + 8'h0C, 32'h0, '1, OK);
      rd(`MIC_OFS_ERR_STAT, 32'h800, 32'h800, OK);
      chk_v(32'(irq), 0);
      wr(`MIC_OFS_IRQ_EN, 32'h2, OK);
      await(0);
      wr(`MIC_OFS_IRQ_CLR, 32'h2, OK);
      rd(`MIC_OFS_IRQ_STAT, 32'h0, 32'h7, OK);
      chk_v(32'(irq), 0);
      $display("refusals and underflow done");
      do_reset();
      wr(`MIC_OFS_CLKDIV, 32'h0, OK);
      wr(`MIC_OFS_DECIM, 32'h1, OK);
      wr(`MIC_OFS_WMARK, 32'h2, OK);
      wr(`MIC_OFS_IRQ_EN, 32'h1, OK);
      wr(`MIC_OFS_CTRL, 32'h3, OK);
      await(0);
      rd(`MIC_OFS_IRQ_STAT, 32'h1, 32'h1, OK);
      chk_v(32'(dma_req), 0);
      for (i = 0; i < 3; i++) begin
         rd(`MIC_OFS_RESULT0, 32'h0, i == 2 ? SGN : 0, OK);
         rd(`MIC_OFS_RESULT0 + 8'h4, SGN, i == 2 ? SGN : 0, OK);
      end
      wr(`MIC_OFS_CTRL, 32'h103, OK);
      await(1);
      wr(`MIC_OFS_IRQ_EN, 32'h2, OK);
      await(0);
      rd(`MIC_OFS_LEVEL0, 32'h20, 32'h3F, OK);
      rd(`MIC_OFS_ERR_STAT, 32'h1, 32'h1, OK);
      $display("watermark and overflow done");
      do_reset();
      wr(`MIC_OFS_CLKDIV, 32'h0, OK);
      wr(`MIC_OFS_IRQ_EN, 32'h4, OK);
      wr(`MIC_OFS_CTRL, 32'h800, OK);
      await(0);
      rd(`MIC_OFS_IRQ_STAT, 32'h4, 32'h4, OK);
      do_reset();
      mode <= 1'b1;
      wr(`MIC_OFS_CLKDIV, 32'h0, OK);
      wr(`MIC_OFS_VAD_THR, 32'h2, OK);
      wr(`MIC_OFS_IRQ_EN, 32'h4, OK);
      wr(`MIC_OFS_CTRL, 32'h1800, OK);
      await(0);
      rd(`MIC_OFS_IRQ_STAT, 32'h4, 32'h4, OK);
      $display("voice detect done");
      complete_run();
   end
endmodule
